// *** rtl/dlwm_top.sv ***
// Drive limit and warning monitor: reference shaping, current cap,
// threshold warnings with routing, and frequency bypass bands.
// Assumes all inputs synchronous to clock_i; settings held steady by
// the control processor; measurements refreshed every cycle.
// Functional notes
// - Catch-up adds percentage to remote reference
// - Slow-down subtracts percentage from remote reference
// - Catch percentage 0 to 100, default 0
// - Cap current at percentage, default 160
// - Cap below rating scales acceleration torque down
// - Low-current warning below threshold, up to high
// - High-current warning above threshold, max default
// - Low-frequency warning below threshold, up to high
// - High-frequency warning, limit 132 or 1000 Hz
// - Low-feedback warning, min -100000, default -4000
// - High-feedback warning, max 100000, default 4000
// - Warnings suppressed while ramping, stopping, stopped
// - Warnings active once output reaches reference
// - Each warning routable to output and relay
// - Two avoided frequencies, zero to 1000 Hz
// - One bandwidth, 0 off to 100 Hz
module dlwm_top
  import dlwm_pkg::*;
(
  // Clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         nrst_i,
  // Run control
  input  wire logic                         start_i,
  input  wire logic                         stop_i,
  input  wire logic                         catch_up_i,
  input  wire logic                         slow_down_i,
  // Reference path (0.1 Hz)
  input  wire logic        [DLWM_REF_W-1:0] remote_ref_i,
  input  wire logic        [DLWM_PCT_W-1:0] catch_pct_i,
  input  wire logic        [1:0]            freq_range_i,
  // Measurements
  input  wire logic        [DLWM_REF_W-1:0] out_freq_i,
  input  wire logic        [DLWM_CUR_W-1:0] out_current_i,
  input  wire logic signed [DLWM_FB_W-1:0]  feedback_i,
  // Current ratings (0.1 A) and cap (0.1 % of motor rating)
  input  wire logic        [DLWM_CUR_W-1:0] motor_rated_current_i,
  input  wire logic        [DLWM_CUR_W-1:0] converter_rated_current_i,
  input  wire logic        [DLWM_CUR_W-1:0] converter_max_current_i,
  input  wire logic        [DLWM_PCT_W-1:0] output_current_cap_i,
  input  wire logic                         cap_use_default_i,
  // Warning thresholds
  input  wire logic        [DLWM_CUR_W-1:0] current_low_threshold_i,
  input  wire logic        [DLWM_CUR_W-1:0] current_high_threshold_i,
  input  wire logic        [DLWM_REF_W-1:0] frequency_low_threshold_i,
  input  wire logic        [DLWM_REF_W-1:0] frequency_high_threshold_i,
  input  wire logic signed [DLWM_FB_W-1:0]  feedback_low_threshold_i,
  input  wire logic signed [DLWM_FB_W-1:0]  feedback_high_threshold_i,
  // Warning routing masks
  input  wire logic        [DLWM_NWARN-1:0] route_signal_i,
  input  wire logic        [DLWM_NWARN-1:0] route_relay_i,
  // Bypass bands
  input  wire logic        [DLWM_REF_W-1:0] bypass_freq1_i,
  input  wire logic        [DLWM_REF_W-1:0] bypass_freq2_i,
  input  wire logic        [DLWM_REF_W-1:0] bypass_width_i,
  // Results
  output logic             [DLWM_REF_W-1:0] shaped_ref_o,
  output logic             [DLWM_CUR_W-1:0] current_cap_o,
  output logic             [DLWM_PCT_W-1:0] accel_torque_pct_o,
  output logic             [DLWM_NWARN-1:0] warnings_o,
  output logic                              warn_signal_o,
  output logic                              warn_relay_o,
  output logic                              warn_active_o
);

  typedef struct packed {
    dlwm_state_t             state;
    logic [DLWM_REF_W-1:0]   adj_ref;
    logic [DLWM_CUR_W-1:0]   cap;
    logic [DLWM_PCT_W-1:0]   torque;
    logic [DLWM_NWARN-1:0]   warn;
    logic                    sig;
    logic                    relay;
  } dlwm_top_state_t;

  dlwm_top_state_t s_q;
  dlwm_top_state_t s_d;

  logic [DLWM_PCT_W-1:0]   pct_c;
  logic [DLWM_PCT_W-1:0]   cap_pct;
  logic [DLWM_REF_W+DLWM_PCT_W-1:0] delta_prod;
  logic [DLWM_REF_W-1:0]   delta;
  logic [DLWM_REF_W:0]     ref_sum;
  logic [DLWM_CUR_W+DLWM_PCT_W-1:0] cap_prod;
  logic [DLWM_CUR_W+DLWM_PCT_W-1:0] cap_lim;
  logic [DLWM_CUR_W+DLWM_PCT_W-1:0] trq_num;
  logic [DLWM_CUR_W+DLWM_PCT_W-1:0] trq_div;
  logic [DLWM_CUR_W-1:0]   i_hi;
  logic [DLWM_CUR_W-1:0]   i_lo;
  logic [DLWM_REF_W-1:0]   f_ceil;
  logic [DLWM_REF_W-1:0]   f_hi;
  logic [DLWM_REF_W-1:0]   f_lo;
  logic signed [DLWM_FB_W-1:0] fb_hi;
  logic signed [DLWM_FB_W-1:0] fb_lo;
  logic [DLWM_NWARN-1:0]   raw;
  logic [DLWM_REF_W-1:0]   bypassed_ref;
  logic                    at_ref;

  assign pct_c = (catch_pct_i > DLWM_PCT_FULL) ? DLWM_PCT_FULL : catch_pct_i;
  assign delta_prod = remote_ref_i * pct_c;
  assign delta = DLWM_REF_W'(delta_prod / DLWM_PCT_FULL);

  always_comb
  begin
    ref_sum = {1'b0, remote_ref_i};
    if (catch_up_i && !slow_down_i)
      ref_sum = {1'b0, remote_ref_i} + {1'b0, delta};
    else if (slow_down_i && !catch_up_i)
      ref_sum = {1'b0, remote_ref_i} - {1'b0, delta};
  end

  // Bypass bands applied to the adjusted reference
  // two avoided frequencies
  dlwm_bypass u_bypass (
    .clock_i        (clock_i),
    .nrst_i         (nrst_i),
    .bypass_freq1_i (bypass_freq1_i),
    .bypass_freq2_i (bypass_freq2_i),
    .bypass_width_i (bypass_width_i),
    .ref_i          (s_q.adj_ref),
    .ref_o          (bypassed_ref)
  );

  assign cap_pct  = cap_use_default_i ? DLWM_CAP_DEFAULT
                                      : output_current_cap_i;
  assign cap_prod = motor_rated_current_i * cap_pct;
  assign cap_lim  = (cap_prod / DLWM_PCT_FULL > converter_max_current_i)
                    ? {{DLWM_PCT_W{1'b0}}, converter_max_current_i}
                    : cap_prod / DLWM_PCT_FULL;

  assign trq_num = cap_lim * DLWM_PCT_FULL;
  assign trq_div = (converter_rated_current_i == '0) ? trq_num
                   : trq_num / converter_rated_current_i;

  // Threshold ranges: low clipped to high, high to ceiling
  // range dependent ceiling
  assign f_ceil = freq_range_i[1] ? DLWM_F_LIM_HI : DLWM_F_LIM_LO;
  assign f_hi   = (frequency_high_threshold_i > f_ceil)
                  ? f_ceil : frequency_high_threshold_i;
  assign f_lo   = (frequency_low_threshold_i > f_hi)
                  ? f_hi : frequency_low_threshold_i;
  assign i_hi   = (current_high_threshold_i > converter_max_current_i)
                  ? converter_max_current_i : current_high_threshold_i;
  assign i_lo   = (current_low_threshold_i > i_hi)
                  ? i_hi : current_low_threshold_i;
  assign fb_hi  = (feedback_high_threshold_i > DLWM_FB_MAX)
                  ? DLWM_FB_MAX : feedback_high_threshold_i;
  assign fb_lo  = (feedback_low_threshold_i < DLWM_FB_MIN) ? DLWM_FB_MIN
                  : ((feedback_low_threshold_i > fb_hi)
                     ? fb_hi : feedback_low_threshold_i);

  // Raw comparisons
  // low current
  assign raw[DLWM_W_ILO]  = out_current_i < i_lo;
  assign raw[DLWM_W_IHI]  = out_current_i > i_hi;
  assign raw[DLWM_W_FLO]  = out_freq_i < f_lo;
  assign raw[DLWM_W_FHI]  = out_freq_i > f_hi;
  assign raw[DLWM_W_FBLO] = feedback_i < fb_lo;
  assign raw[DLWM_W_FBHI] = feedback_i > fb_hi;

  // Output frequency has reached the shaped reference
  assign at_ref = (out_freq_i == bypassed_ref);

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.adj_ref = ref_sum[DLWM_REF_W] ? '0 : ref_sum[DLWM_REF_W-1:0];
    s_d.cap = cap_lim[DLWM_CUR_W-1:0];
    s_d.torque = (trq_div > {{DLWM_CUR_W{1'b0}}, DLWM_PCT_FULL})
                 ? DLWM_PCT_FULL : trq_div[DLWM_PCT_W-1:0];
    case (s_q.state)
      DLWM_ST_IDLE:
        if (start_i && !stop_i)
          s_d.state = DLWM_ST_RAMP;
      DLWM_ST_RAMP:
        if (stop_i || !start_i)
          s_d.state = DLWM_ST_IDLE;
        else if (at_ref)
          s_d.state = DLWM_ST_RUN;
      DLWM_ST_RUN:
        if (stop_i || !start_i)
          s_d.state = DLWM_ST_IDLE;
      default:
        s_d.state = DLWM_ST_IDLE;
    endcase
    s_d.warn = (s_q.state == DLWM_ST_RUN && s_d.state == DLWM_ST_RUN)
               ? raw : '0;
    s_d.sig   = |(s_d.warn & route_signal_i);
    s_d.relay = |(s_d.warn & route_relay_i);
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      s_q       <= '0;
      s_q.state <= DLWM_ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign shaped_ref_o       = bypassed_ref;
  assign current_cap_o      = s_q.cap;
  assign accel_torque_pct_o = s_q.torque;
  assign warnings_o         = s_q.warn;
  assign warn_signal_o      = s_q.sig;
  assign warn_relay_o       = s_q.relay;
  assign warn_active_o      = (s_q.state == DLWM_ST_RUN);
endmodule

// *** rtl/dlwm_pkg.sv ***
// Package for the drive limit / warning monitor.
// Assumes fixed-point quantities: current and percent in 0.1 units,
// frequency in 0.1 Hz, feedback in 0.001 units (signed).
package dlwm_pkg;
  // Data widths
  localparam int unsigned DLWM_REF_W = 16;  // Reference / frequency, 0.1 Hz
  localparam int unsigned DLWM_CUR_W = 16;  // Current, 0.1 A
  localparam int unsigned DLWM_PCT_W = 11;  // Percent, 0.1 %
  localparam int unsigned DLWM_FB_W  = 32;  // Feedback, 0.001 units
  localparam int unsigned DLWM_NWARN = 6;

  // Percent scale and limits (0.1 % units)
  localparam logic [10:0] DLWM_PCT_FULL     = 11'h3_E8;  // 100.0 %
  localparam logic [10:0] DLWM_PCT_CAP_MAX  = 11'h7_FF;  // Largest cap
  localparam logic [10:0] DLWM_CAP_DEFAULT  = 11'h6_40;  // 160.0 %
  localparam logic [10:0] DLWM_CATCH_DEF    = 11'h0_00;  // 0.00 %

  // Frequency limits (0.1 Hz units)
  localparam logic [15:0] DLWM_F_LIM_LO     = 16'h0_528;  // 132.0 Hz
  localparam logic [15:0] DLWM_F_LIM_HI     = 16'h2_710;  // 1000.0 Hz
  localparam logic [15:0] DLWM_F_HIGH_DEF   = 16'h0_528;  // 132.0 Hz
  localparam logic [15:0] DLWM_F_LOW_DEF    = 16'h0_000;  // 0.0 Hz
  localparam logic [15:0] DLWM_BW_MAX       = 16'h0_3E8;  // 100.0 Hz

  // Current defaults (0.1 A units)
  localparam logic [15:0] DLWM_I_LOW_DEF    = 16'h0_000;  // 0.0 A

  // Feedback limits (0.001 units)
  localparam logic signed [31:0] DLWM_FB_MAX     = 32'h05F5_E100; // 1e5
  localparam logic signed [31:0] DLWM_FB_MIN     = 32'hFA0A_1F00; // -1e5
  localparam logic signed [31:0] DLWM_FB_HI_DEF  = 32'h003D_0900; // 4000
  localparam logic signed [31:0] DLWM_FB_LO_DEF  = 32'hFFC2_F700; // -4000

  // Warning vector bit positions
  localparam int unsigned DLWM_W_ILO  = 0;
  localparam int unsigned DLWM_W_IHI  = 1;
  localparam int unsigned DLWM_W_FLO  = 2;
  localparam int unsigned DLWM_W_FHI  = 3;
  localparam int unsigned DLWM_W_FBLO = 4;
  localparam int unsigned DLWM_W_FBHI = 5;

  // Supervision states
  typedef enum logic [1:0] {
    DLWM_ST_IDLE,
    DLWM_ST_RAMP,
    DLWM_ST_RUN
  } dlwm_state_t;
endpackage

// *** rtl/dlwm_bypass.sv ***
// Frequency bypass band: moves a reference out of two resonance bands.
// Assumes a settled reference input; result is registered.
module dlwm_bypass
  import dlwm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  // Band settings
  input  wire logic [DLWM_REF_W-1:0] bypass_freq1_i,
  input  wire logic [DLWM_REF_W-1:0] bypass_freq2_i,
  input  wire logic [DLWM_REF_W-1:0] bypass_width_i,
  // Reference in and out
  input  wire logic [DLWM_REF_W-1:0] ref_i,
  output logic      [DLWM_REF_W-1:0] ref_o
);

  typedef struct packed {
    logic [DLWM_REF_W-1:0] ref_out;
  } dlwm_byp_state_t;

  dlwm_byp_state_t s_q;
  dlwm_byp_state_t s_d;
  logic [DLWM_REF_W-1:0] width_c;
  logic [DLWM_REF_W-1:0] center [2];
  logic [DLWM_REF_W-1:0] stage [3];

  // Width clipped to its 100 Hz ceiling
  assign width_c = (bypass_width_i > DLWM_BW_MAX) ? DLWM_BW_MAX
                                                  : bypass_width_i;
  assign center[0] = (bypass_freq1_i > DLWM_F_LIM_HI) ? DLWM_F_LIM_HI
                                                      : bypass_freq1_i;
  assign center[1] = (bypass_freq2_i > DLWM_F_LIM_HI) ? DLWM_F_LIM_HI
                                                      : bypass_freq2_i;
  assign stage[0] = ref_i;

  // One band stage per avoided frequency
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_band
      logic [DLWM_REF_W:0] half;
      logic [DLWM_REF_W:0] lo_edge;
      logic [DLWM_REF_W:0] hi_edge;
      logic [DLWM_REF_W:0] cur;
      logic [DLWM_REF_W-1:0] snapped;
      assign half    = {2'b00, width_c[DLWM_REF_W-1:1]};
      assign cur     = {1'b0, stage[g]};
      assign lo_edge = ({1'b0, center[g]} > half)
                       ? ({1'b0, center[g]} - half) : '0;
      assign hi_edge = {1'b0, center[g]} + half;
      always_comb
      begin
        snapped = stage[g];
        if ((width_c != '0) && (cur > lo_edge) && (cur < hi_edge))
        begin
          if ((cur - lo_edge) <= (hi_edge - cur))
            snapped = lo_edge[DLWM_REF_W-1:0];
          else
            snapped = hi_edge[DLWM_REF_W-1:0];
        end
      end
      // Every stage entry has one continuous driver
      assign stage[g+1] = snapped;
    end
  endgenerate

  // Next output value
  always_comb
  begin
    s_d = s_q;
    s_d.ref_out = stage[2];
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ref_o = s_q.ref_out;
endmodule

// *** sim/dlwm_top_assertions.sv ***
// Checker for the warning monitor, watching top-level ports only.
// Assumes one clock domain with a synchronous active-low reset.
module dlwm_checker
  import dlwm_pkg::*;
(
  // Clock, reset and run control
  input wire logic                  clock_i,
  input wire logic                  nrst_i,
  input wire logic                  start_i,
  input wire logic                  stop_i,
  // Measurements and settings
  input wire logic [DLWM_REF_W-1:0] out_freq_i,
  input wire logic [DLWM_CUR_W-1:0] out_current_i,
  input wire logic [DLWM_CUR_W-1:0] converter_max_current_i,
  input wire logic [DLWM_CUR_W-1:0] current_low_threshold_i,
  input wire logic [DLWM_CUR_W-1:0] current_high_threshold_i,
  input wire logic [DLWM_NWARN-1:0] route_signal_i,
  input wire logic [DLWM_NWARN-1:0] route_relay_i,
  // Results
  input wire logic [DLWM_REF_W-1:0] shaped_ref_o,
  input wire logic [DLWM_CUR_W-1:0] current_cap_o,
  input wire logic [DLWM_NWARN-1:0] warnings_o,
  input wire logic                  warn_signal_o,
  input wire logic                  warn_relay_o,
  input wire logic                  warn_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  warn_idle_a: assert property (
    !warn_active_o |=> warnings_o == '0)
    else $error("warning raised while unarmed");
  stop_disarm_a: assert property (
    stop_i |=> !warn_active_o)
    else $error("still armed after stop");
  arm_at_ref_a: assert property (
    $rose(warn_active_o) |-> $past(out_freq_i == shaped_ref_o))
    else $error("armed before frequency reached reference");
  low_cur_raise_a: assert property (
    warn_active_o && start_i && !stop_i
    && out_current_i < current_low_threshold_i
    && current_low_threshold_i <= current_high_threshold_i
    |=> warnings_o[DLWM_W_ILO])
    else $error("low current warning missing");
  high_cur_raise_a: assert property (
    warn_active_o && start_i && !stop_i
    && out_current_i > current_high_threshold_i
    && current_high_threshold_i <= converter_max_current_i
    |=> warnings_o[DLWM_W_IHI])
    else $error("high current warning missing");
  low_cur_clear_a: assert property (
    warnings_o[DLWM_W_ILO] |-> $past(out_current_i < current_low_threshold_i))
    else $error("low current warning without cause");
  signal_route_a: assert property (
    $stable(route_signal_i)
    |-> warn_signal_o == |(warnings_o & route_signal_i))
    else $error("signal output disagrees with routing");
  relay_route_a: assert property (
    $stable(route_relay_i) |-> warn_relay_o == |(warnings_o & route_relay_i))
    else $error("relay output disagrees with routing");
  cap_bound_a: assert property (
    current_cap_o <= $past(converter_max_current_i))
    else $error("current cap above converter maximum");
endmodule

bind dlwm_top dlwm_checker dlwm_checker_inst (.*);

// *** sim/dlwm_load_model.sv ***
// Motor load model: output frequency slews toward the shaped reference.
// Assumes the bench clock and reset; the slew step is a plain parameter.
module dlwm_load_model #(
  parameter logic [15:0] STEP = 16'h0040
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Target and measured frequency
  input  wire logic [15:0] target_i,
  output logic      [15:0] freq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One step per cycle, settling exactly on the target
  always @(posedge clock_i)
  begin
    if (!nrst_i)
      freq_o <= 16'h0000;
    else if (target_i > freq_o + STEP)
      freq_o <= freq_o + STEP;
    else if (freq_o > target_i + STEP)
      freq_o <= freq_o - STEP;
    else
      freq_o <= target_i;
  end
endmodule

// *** sim/dlwm_top_test.sv ***
// Self-checking bench for the drive limit and warning monitor.
// Assumes the load model closes the frequency loop; inputs move on negedge.
`define CHECK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module dlwm_top_test
  import dlwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic cu; logic sd; logic [10:0] pct; logic [15:0] rref;
    logic capdef; logic [10:0] cappct;
    logic [15:0] eref; logic [15:0] ecap; logic [10:0] etq;
  } dlwm_row_t;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i, stop_i, catch_up_i, slow_down_i, cap_use_default_i;
  logic [1:0] freq_range_i;
  logic [10:0] catch_pct_i, output_current_cap_i;
  logic [15:0] remote_ref_i, out_freq_i, out_current_i, shaped_ref_o;
  logic [15:0] motor_rated_current_i, converter_rated_current_i;
  logic [15:0] converter_max_current_i, current_cap_o;
  logic [15:0] current_low_threshold_i, current_high_threshold_i;
  logic [15:0] frequency_low_threshold_i, frequency_high_threshold_i;
  logic [15:0] bypass_freq1_i, bypass_freq2_i, bypass_width_i;
  logic signed [31:0] feedback_i, feedback_low_threshold_i;
  logic signed [31:0] feedback_high_threshold_i;
  logic [5:0] route_signal_i, route_relay_i, warnings_o;
  logic [10:0] accel_torque_pct_o;
  logic warn_signal_o, warn_relay_o, warn_active_o;
  int mismatches = 0;
  int checked = 0;
  dlwm_row_t rows [6] = '{
  '{1'b0, 1'b0, 11'h064, 16'h03E8, 1'b1, 11'h000, 16'h03E8, 16'h00A0, 11'h320},
  '{1'b1, 1'b0, 11'h064, 16'h03E8, 1'b0, 11'h1F4, 16'h044C, 16'h0032, 11'h0FA},
  '{1'b0, 1'b1, 11'h064, 16'h03E8, 1'b0, 11'h3E8, 16'h0384, 16'h0064, 11'h1F4},
  '{1'b1, 1'b1, 11'h064, 16'h03E8, 1'b0, 11'h7D0, 16'h03E8, 16'h00C8, 11'h3E8},
  '{1'b1, 1'b0, 11'h7D0, 16'h03E8, 1'b0, 11'h000, 16'h07D0, 16'h0000, 11'h000},
  '{1'b0, 1'b1, 11'h3E8, 16'h0190, 1'b0, 11'h3E8, 16'h0000, 16'h0064, 11'h1F4}
  };

  // Free-running 50 MHz clock
  always #10 clock_i = ~clock_i;

  dlwm_top dlwm_top_inst (.*);
  dlwm_load_model dlwm_load_model_inst (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .target_i (shaped_ref_o),
    .freq_o   (out_freq_i)
  );

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // One warning cause over a quiet baseline; 6 means none
  task automatic set_cause(input int k);
    out_current_i = (k == 0) ? 16'h000A : (k == 1) ? 16'h0258 : 16'h00C8;
    frequency_low_threshold_i = (k == 2) ? 16'h044C : 16'h01F4;
    frequency_high_threshold_i = (k == 3) ? 16'h0384 : 16'h0528;
    feedback_i = (k == 4) ? 32'shFFB3_B4C0 : (k == 5) ? 32'sh004C_4B40 : '0;
  endtask

  task automatic bypass_case(input logic [15:0] r, input logic [15:0] e);
    remote_ref_i = r;
    cycles(3);
    `CHECK("bypass ref", e, shaped_ref_o)
  endtask

  // Main sequence: reset, table, bypass bands, warnings, stop
  initial
  begin
    {start_i, stop_i, catch_up_i, slow_down_i, cap_use_default_i} = '0;
    {remote_ref_i, catch_pct_i, freq_range_i} = {16'h03E8, 11'h000, 2'h2};
    motor_rated_current_i = 16'h0064;
    converter_rated_current_i = 16'h00C8;
    converter_max_current_i = 16'h03E8;
    output_current_cap_i = 11'h3E8;
    current_low_threshold_i = 16'h0032;
    current_high_threshold_i = 16'h01F4;
    feedback_low_threshold_i = DLWM_FB_LO_DEF;
    feedback_high_threshold_i = DLWM_FB_HI_DEF;
    {route_signal_i, route_relay_i} = {6'h15, 6'h2A};
    {bypass_freq1_i, bypass_freq2_i, bypass_width_i} =
      {16'h03E8, 16'h0BB8, 16'h0000};
    set_cause(6);
    cycles(3);
    `CHECK("cap in reset", 16'h0000, current_cap_o)
    `CHECK("armed in reset", 1'b0, warn_active_o)
    nrst_i = 1'b1;
    cycles(1);
    // First edge after release already loads the computed cap
    `CHECK("cap after reset", 16'h0064, current_cap_o)
    foreach (rows[i])
    begin
      {catch_up_i, slow_down_i} = {rows[i].cu, rows[i].sd};
      {catch_pct_i, remote_ref_i} = {rows[i].pct, rows[i].rref};
      cap_use_default_i = rows[i].capdef;
      output_current_cap_i = rows[i].cappct;
      cycles(3);
      `CHECK("shaped ref", rows[i].eref, shaped_ref_o)
      `CHECK("current cap", rows[i].ecap, current_cap_o)
      `CHECK("accel torque", rows[i].etq, accel_torque_pct_o)
    end
    {catch_up_i, slow_down_i, catch_pct_i} = '0;
    bypass_width_i = 16'h0064;
    bypass_case(16'h03FC, 16'h041A);
    bypass_case(16'h03DE, 16'h03B6);
    bypass_case(16'h03E8, 16'h03B6);
    bypass_case(16'h041A, 16'h041A);
    bypass_case(16'h0BE0, 16'h0BEA);
    {bypass_width_i, remote_ref_i} = {16'h0000, 16'h03E8};
    set_cause(0);
    start_i = 1'b1;
    for (int n = 0; n < 400 && warn_active_o !== 1'b1; n++)
    begin
      `CHECK("ramp warnings", 6'h00, warnings_o)
      cycles(1);
    end
    `CHECK("armed", 1'b1, warn_active_o)
    `CHECK("first run warnings", 6'h00, warnings_o)
    for (int k = 0; k < 6; k++)
    begin
      set_cause(k);
      cycles(2);
      `CHECK("warnings", 6'h01 << k, warnings_o)
      `CHECK("signal", |(6'h15 & (6'h01 << k)), warn_signal_o)
      `CHECK("relay", |(6'h2A & (6'h01 << k)), warn_relay_o)
      set_cause(6);
      cycles(2);
      `CHECK("warning clear", 6'h00, warnings_o)
    end
    // Narrow range caps the high threshold at 132 Hz
    remote_ref_i = 16'h0640;
    frequency_high_threshold_i = 16'h0FA0;
    cycles(20);
    `CHECK("wide range", 6'h00, warnings_o)
    freq_range_i = 2'h0;
    cycles(2);
    `CHECK("narrow range", 6'h08, warnings_o)
    `CHECK("narrow relay", 1'b1, warn_relay_o)
    set_cause(1);
    stop_i = 1'b1;
    cycles(2);
    `CHECK("stop disarm", 1'b0, warn_active_o)
    `CHECK("stop warnings", 6'h00, warnings_o)
    // Reset in mid-run clears the registers, release reloads them
    nrst_i = 1'b0;
    cycles(1);
    `CHECK("cap in mid reset", 16'h0000, current_cap_o)
    `CHECK("ref in mid reset", 16'h0000, shaped_ref_o)
    nrst_i = 1'b1;
    cycles(2);
    `CHECK("cap after mid reset", 16'h0064, current_cap_o)
    `CHECK("ref after mid reset", 16'h0640, shaped_ref_o)
    `CHECK("armed after mid reset", 1'b0, warn_active_o)
    test_done();
  end

  // Cut a hang short well after the expected run length
  initial
  begin
    #40000;
    mismatches++;
    test_done();
  end
endmodule
